// ==== rtl/spfc_defines.vh ====
// Notes on behaviour
// - boot size setting picks boot start address
// - words below 0x3800 are read-while-write section
// - during rww page programming fetch only from no-rww section; no fetch during no-rww page programming
// - 14-bit pc, 64-word pages
// - page number from pointer bits 14..7
// - word in page from bits 6..1
// - pointer bit 15 always ignored
// - pointer bit 0 is byte select
// - control register at 0x37, resets zero
// - ready interrupt needs enable bit and global flag
// - ready interrupt is level while enable clear
// - section unreadable while busy; read-enable clears
// - only five low command patterns take effect
// - enable arms store for four cycles
// - rww programming sets busy; load clears it
`ifndef SPFC_DEFINES_VH
`define SPFC_DEFINES_VH
`define SPFC_ADR_CSR 8'h37
`define SPFC_ADR_MEM 8'h57
`define SPFC_ADR_IRQ_STAT 8'h40
`define SPFC_ADR_IRQ_EN 8'h41
`define SPFC_ADR_IRQ_CLR 8'h42
`define SPFC_ADR_BOOT_SIZE 8'h43
`define SPFC_ADR_ZPTR_LO 8'h44
`define SPFC_ADR_ZPTR_HI 8'h45
`define SPFC_ADR_PAGE 8'h46
`define SPFC_CSR_RESET 8'h00
`define SPFC_B_IE 7
`define SPFC_B_BUSY 6
`define SPFC_B_RRE 4
`define SPFC_B_LBS 3
`define SPFC_B_PGW 2
`define SPFC_B_PGE 1
`define SPFC_B_EN 0
`define SPFC_CMD_RRE 5'h11
`define SPFC_CMD_LBS 5'h09
`define SPFC_CMD_PGW 5'h05
`define SPFC_CMD_LOAD 5'h01
`define SPFC_CMD_PGE 5'h03
`define SPFC_ARM_CYC 3'd4
`define SPFC_NO_READ_WHILE_WRITE_SECTION_START 14'h3800
`define SPFC_BOOT_11 14'h3f00
`define SPFC_BOOT_10 14'h3e00
`define SPFC_BOOT_01 14'h3c00
`define SPFC_BOOT_00 14'h3800
`define SPFC_PROG_NS 3700000
`define SPFC_CLK_MHZ 40
`define SPFC_PROG_CYC ((`SPFC_PROG_NS * `SPFC_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/spfc_addr_map.v ====
`timescale 1ns/1ps
`include "spfc_defines.vh"
module spfc_addr_map
(
  input wire [15:0] zptr,
  input wire [1:0] boot_size_setting,
  input wire [13:0] pc,
  output wire [7:0] page_number_field,
  output wire [5:0] word_in_page_field,
  output wire byte_select,
  output wire page_in_rww,
  output wire pc_in_no_read_while_write_section,
  output wire pc_in_boot,
  output wire [13:0] boot_start
);
  reg [13:0] start;
  always @*
  begin
    case (boot_size_setting)
      2'b11: start = `SPFC_BOOT_11;
      2'b10: start = `SPFC_BOOT_10;
      2'b01: start = `SPFC_BOOT_01;
      default: start = `SPFC_BOOT_00;
    endcase
  end
  assign boot_start = start;
  assign page_number_field = zptr[14:7];
  assign word_in_page_field = zptr[6:1];
  assign byte_select = zptr[0];
  assign page_in_rww = ({zptr[14:7], 6'h00} < `SPFC_NO_READ_WHILE_WRITE_SECTION_START);
  assign pc_in_no_read_while_write_section = (pc >= `SPFC_NO_READ_WHILE_WRITE_SECTION_START);
  assign pc_in_boot = (pc >= start);
endmodule // spfc_addr_map

// ==== rtl/spfc_top.v ====
`timescale 1ns/1ps
`include "spfc_defines.vh"
module spfc_top
#(
  parameter PROG_CYC = `SPFC_PROG_CYC
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  output reg [7:0] wb_dat_o,
  input wire wb_we_i,
  input wire wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire global_int_flag,
  input wire eeprom_write_pending,
  input wire spm_exec,
  input wire [13:0] pc,
  input wire [1:0] boot_size_setting,
  output reg irq,
  output reg ready_irq,
  output reg rw_section_busy_o,
  output reg fetch_stall,
  output reg buf_we,
  output reg [5:0] buf_word,
  output reg buf_clear,
  output reg flash_erase,
  output reg flash_write,
  output reg lock_write,
  output reg [7:0] flash_page
);
  ////////////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 2'd0;
  localparam S_ARM = 2'd1;
  localparam S_PROG = 2'd2;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] csr_r;
  reg [2:0] arm_cnt_r;
  reg [31:0] prog_cnt_r;
  reg [15:0] zptr_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;
  reg prog_rww_r;
  wire [7:0] page;
  wire [5:0] word;
  wire byte_sel;
  wire page_rww;
  wire pc_no_read_while_write_section;
  wire pc_boot;
  wire [13:0] boot_start;
  spfc_addr_map u_map
  (
    .zptr(zptr_r),
    .boot_size_setting(boot_size_setting),
    .pc(pc),
    .page_number_field(page),
    .word_in_page_field(word),
    .byte_select(byte_sel),
    .page_in_rww(page_rww),
    .pc_in_no_read_while_write_section(pc_no_read_while_write_section),
    .pc_in_boot(pc_boot),
    .boot_start(boot_start)
  );
  ////////////////////////////////////////////////////////////////////////////
  function valid_cmd;
    input [4:0] c;
    begin
      valid_cmd = (c == `SPFC_CMD_RRE) || (c == `SPFC_CMD_LBS) ||
        (c == `SPFC_CMD_PGW) || (c == `SPFC_CMD_LOAD) || (c == `SPFC_CMD_PGE);
    end
  endfunction
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i;
  wire csr_hit = (wb_adr_i == `SPFC_ADR_CSR) || (wb_adr_i == `SPFC_ADR_MEM);
  wire csr_wr = bus_wr & csr_hit & (state_r == S_IDLE) & ~eeprom_write_pending;
  wire cmd_ok = csr_wr & valid_cmd(wb_dat_i[4:0]);
  wire [4:0] cmd = csr_r[4:0];
  wire spm_go = (state_r == S_ARM) & spm_exec;
  wire arm_exp = (state_r == S_ARM) & (arm_cnt_r == 3'd1) & ~spm_exec;
  wire prog_done = (state_r == S_PROG) & (prog_cnt_r == 32'd1);
  wire starts_prog = spm_go & ((cmd == `SPFC_CMD_PGE) || (cmd == `SPFC_CMD_PGW)
    || (cmd == `SPFC_CMD_LBS));
  wire [2:0] ev = {arm_exp, prog_done, spm_go};
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
      begin
        if (cmd_ok)
          state_nxt = S_ARM;
      end
      S_ARM:
      begin
        if (starts_prog)
          state_nxt = S_PROG;
        else if (spm_go || arm_exp)
          state_nxt = S_IDLE;
      end
      S_PROG:
      begin
        if (prog_done)
          state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      csr_r <= `SPFC_CSR_RESET;
      arm_cnt_r <= 3'd0;
      prog_cnt_r <= 32'd0;
      zptr_r <= 16'h0000;
      irq_stat_r <= 3'b000;
      irq_en_r <= 3'b000;
      prog_rww_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
      irq <= 1'b0;
      ready_irq <= 1'b0;
      rw_section_busy_o <= 1'b0;
      fetch_stall <= 1'b0;
      buf_we <= 1'b0;
      buf_word <= 6'h00;
      buf_clear <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      lock_write <= 1'b0;
      flash_page <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      wb_ack_o <= bus_req;
      buf_we <= 1'b0;
      buf_clear <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      lock_write <= 1'b0;
      if (bus_wr && csr_hit)
        csr_r[`SPFC_B_IE] <= wb_dat_i[`SPFC_B_IE];
      if (cmd_ok)
      begin
        csr_r[4:0] <= wb_dat_i[4:0];
        arm_cnt_r <= `SPFC_ARM_CYC;
      end
      else if (state_r == S_ARM)
        arm_cnt_r <= arm_cnt_r - 3'd1;
      if (bus_wr && wb_adr_i == `SPFC_ADR_ZPTR_LO)
        zptr_r[7:0] <= wb_dat_i;
      if (bus_wr && wb_adr_i == `SPFC_ADR_ZPTR_HI)
        zptr_r[15:8] <= wb_dat_i;
      if (spm_go)
      begin
        case (cmd)
          `SPFC_CMD_LOAD:
          begin
            buf_we <= 1'b1;
            buf_word <= word;
            csr_r[`SPFC_B_BUSY] <= 1'b0;
          end
          `SPFC_CMD_RRE:
          begin
            buf_clear <= 1'b1;
            csr_r[`SPFC_B_BUSY] <= 1'b0;
          end
          `SPFC_CMD_PGE, `SPFC_CMD_PGW:
          begin
            flash_erase <= (cmd == `SPFC_CMD_PGE);
            flash_write <= (cmd == `SPFC_CMD_PGW);
            flash_page <= page;
            prog_rww_r <= page_rww;
            if (page_rww)
              csr_r[`SPFC_B_BUSY] <= 1'b1;
          end
          `SPFC_CMD_LBS: lock_write <= 1'b1;
          default: buf_we <= 1'b0;
        endcase
      end
      if (starts_prog)
        prog_cnt_r <= PROG_CYC;
      else if (state_r == S_PROG)
        prog_cnt_r <= prog_cnt_r - 32'd1;
      if ((spm_go && !starts_prog) || arm_exp || prog_done)
        csr_r[4:0] <= 5'h00;
      // stall fetch outside no_read_while_write_section during rww page program, always for no_read_while_write_section page
      fetch_stall <= (state_nxt == S_PROG) && (starts_prog || state_r == S_PROG)
        && ((starts_prog ? !page_rww : !prog_rww_r) || !pc_no_read_while_write_section);
      rw_section_busy_o <= csr_r[`SPFC_B_BUSY];
      ready_irq <= csr_r[`SPFC_B_IE] & global_int_flag & ~csr_r[`SPFC_B_EN];
      irq_stat_r <= (irq_stat_r & ~((bus_wr && wb_adr_i == `SPFC_ADR_IRQ_CLR) ?
        wb_dat_i[2:0] : 3'b000)) | ev;
      if (bus_wr && wb_adr_i == `SPFC_ADR_IRQ_EN)
        irq_en_r <= wb_dat_i[2:0];
      irq <= |(irq_stat_r & irq_en_r);
      if (bus_req)
      begin
        case (wb_adr_i)
          `SPFC_ADR_CSR, `SPFC_ADR_MEM: wb_dat_o <= csr_r & 8'hdf;
          `SPFC_ADR_IRQ_STAT: wb_dat_o <= {5'h00, irq_stat_r};
          `SPFC_ADR_IRQ_EN: wb_dat_o <= {5'h00, irq_en_r};
          `SPFC_ADR_BOOT_SIZE: wb_dat_o <= {5'h00, pc_boot, boot_size_setting};
          `SPFC_ADR_ZPTR_LO: wb_dat_o <= zptr_r[7:0];
          `SPFC_ADR_ZPTR_HI: wb_dat_o <= zptr_r[15:8];
          `SPFC_ADR_PAGE: wb_dat_o <= {byte_sel, 1'b0, boot_start[13:8]};
          default: wb_dat_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // spfc_top

// ==== dv/spfc_monitor.sv ====
`timescale 1ns/1ps
module spfc_monitor
(
  input wire ref_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire global_int_flag,
  input wire spm_exec,
  input wire ready_irq,
  input wire rw_section_busy_o,
  input wire buf_we,
  input wire buf_clear,
  input wire fetch_stall,
  input wire flash_erase,
  input wire flash_write,
  input wire lock_write,
  input wire [7:0] flash_page
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_load_by_store: assert property (buf_we |-> $past(spm_exec))
    else $error("load without store");
  a_erase_by_store: assert property (flash_erase |-> $past(spm_exec))
    else $error("erase without store");
  a_write_by_store: assert property (flash_write |-> $past(spm_exec))
    else $error("write without store");
  a_lock_by_store: assert property (lock_write |-> $past(spm_exec))
    else $error("lock without store");
  a_ready_needs_flag: assert property (ready_irq |-> $past(global_int_flag))
    else $error("ready irq without flag");
  a_busy_on_rww: assert property ((flash_erase || flash_write) && flash_page < 8'he0
    |-> ##[1:3] rw_section_busy_o) else $error("busy not set");
  a_load_clears_busy: assert property (buf_we |-> ##[1:3] !rw_section_busy_o)
    else $error("busy not cleared");
  a_clear_by_store: assert property (buf_clear |-> $past(spm_exec))
    else $error("read enable without store");
  a_stall_no_read_while_write_section_page: assert property ((flash_erase || flash_write) && flash_page >= 8'he0
    |-> fetch_stall) else $error("no stall on no_read_while_write_section page");
endmodule // spfc_monitor
bind spfc_top spfc_monitor u_mon(.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .global_int_flag, .spm_exec, .ready_irq, .rw_section_busy_o, .buf_we, .buf_clear,
  .fetch_stall, .flash_erase,
  .flash_write, .lock_write, .flash_page);

// ==== dv/spfc_cpu_model.sv ====
`timescale 1ns/1ps
module spfc_cpu_model
(
  input wire ref_clk,
  input wire go,
  input wire dly,
  output reg spm_exec,
  output reg [13:0] pc
);
  reg cnt_r = 1'b0;
  initial spm_exec = 1'b0;
  initial pc = 14'h3f00;
  // loader code fetches from the no_read_while_write_section space only
  always @(posedge ref_clk)
  begin
    spm_exec <= (go && !dly) || cnt_r;
    cnt_r <= go && dly;
    pc <= 14'h3f00 + {13'h0, go};
  end
endmodule // spfc_cpu_model

// ==== dv/spfc_tb_top.sv ====
`timescale 1ns/1ps
module spfc_tb_top;
  reg clk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0, gif = 0, eep = 0, go = 0, dly = 0, cr = 0;
  reg [7:0] adr = 0, dat = 0, rdat;
  reg [1:0] bss = 0;
  reg [31:0] rs = 32'hf3b8a45b;
  reg [15:0] z;
  int fail_count = 0, cmp_count = 0, n, i, k;
  reg [7:0] rq[$], pq[$];
  wire ack, irq, rdy, bsy, bwe, fe, fw, lw, spm;
  wire [7:0] dato, pg;
  wire [5:0] bw;
  wire [13:0] pc;
  always #12.5 clk = ~clk;
  spfc_top #(.PROG_CYC(20)) u_dut(.ref_clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dato), .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .global_int_flag(gif), .eeprom_write_pending(eep), .spm_exec(spm),
    .pc(pc), .boot_size_setting(bss), .irq(irq), .ready_irq(rdy), .rw_section_busy_o(bsy),
    .fetch_stall(), .buf_we(bwe), .buf_word(bw), .buf_clear(), .flash_erase(fe),
    .flash_write(fw), .lock_write(lw), .flash_page(pg));
  spfc_cpu_model u_cpu(.ref_clk(clk), .go(go), .dly(dly), .spm_exec(spm), .pc(pc));
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task end_of_test;
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task stop;
    fail_count++;
    end_of_test;
  endtask
  task bus(input [7:0] a, input [7:0] d, input w, input c = 1'b0);
    @(posedge clk);
    cr <= c;
    adr <= a;
    dat <= d;
    we <= w;
    cyc <= 1;
    stb <= 1;
    for (n = 0; !ack; n++)
    begin
      if (n > 9) stop;
      @(posedge clk);
    end
    rdat = dato;
    cyc <= 0;
    stb <= 0;
    cr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    rq.push_back(e);
    bus(a, 0, 0, 1);
  endtask
  task pol;
    for (i = 0; i < 60; i++)
    begin
      bus(8'h37, 0, 0);
      if (!rdat[0]) break;
    end
    if (i == 60) stop;
  endtask
  task cmd(input [7:0] c);
    pol;
    gif <= 0;
    bus(8'h37, c, 1);
    dly <= rs[0];
    go <= 1;
    @(posedge clk) go <= 0;
    repeat (2) @(posedge clk);
    rs = xs(rs);
  endtask
  task setz;
    bus(8'h44, z[7:0], 1);
    bus(8'h45, z[15:8], 1);
  endtask
  always @(posedge clk)
  begin
    if (ack && !we && cr) chk(dato, rq.pop_front());
    if (bwe) chk({2'b0, bw}, pq.pop_front());
    if (fe || fw) chk(pg, pq.pop_front());
    if (lw) chk(lw, pq.pop_front());
  end
  initial
  begin
    #2000000;
    stop;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rd(8'h37, 0);
    rd(8'h57, 0);
    rd(8'h7f, 0);
    rd(8'h40, 0);
    z = xs(rs) & 16'hfffe;
    setz;
    pq.push_back({2'b0, z[6:1]});
    cmd(8'h01);
    rd(8'h37, 0);
    rd(8'h40, 8'h01);
    bus(8'h41, 1, 1);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    bus(8'h42, 1, 1);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    bus(8'h41, 0, 1);
    bus(8'h37, 8'h01, 1);
    repeat (6) @(posedge clk);
    rd(8'h37, 0);
    rd(8'h40, 8'h04);
    bus(8'h37, 8'h87, 1);
    rd(8'h37, 8'h80);
    gif <= 1;
    repeat (2) @(posedge clk);
    chk(rdy, 1);
    gif <= 0;
    repeat (2) @(posedge clk);
    chk(rdy, 0);
    eep <= 1;
    bus(8'h37, 8'h01, 1);
    rd(8'h37, 0);
    eep <= 0;
    for (k = 0; k < 2; k++)
    begin
      z = xs(rs);
      rs = z;
      z[14:7] = k ? (z[14:7] | 8'he0) : (z[14:7] & 8'hdf);
      z[6:0] = 0;
      setz;
      pq.push_back(z[14:7]);
      cmd(k ? 8'h05 : 8'h03);
      pol;
      rd(8'h37, k ? 8'h00 : 8'h40);
      cmd(8'h11);
      pol;
      rd(8'h37, 0);
    end
    z[14:7] = 8'h00;
    setz;
    pq.push_back(8'h00);
    cmd(8'h03);
    pol;
    pq.push_back(8'h00);
    cmd(8'h01);
    rd(8'h37, 0);
    pq.push_back(8'h01);
    cmd(8'h09);
    pol;
    rd(8'h37, 0);
    rd(8'h40, 8'h07);
    bus(8'h44, 8'h01, 1);
    for (k = 0; k < 4; k++)
    begin
      bss <= k[1:0];
      rd(8'h46, 8'hc0 - (8'h08 >> k));
    end
    chk(pq.size(), 0);
    end_of_test;
  end
endmodule // spfc_tb_top
